// ==== include/pas_defs.vh ====
// Functional notes
// R1: Pending pairs are serviced in ascending order, lowest-numbered pair first.
// R2: Each input pair selects its own trigger from sixteen sources.
// R3: Up to four inputs sample together; twelve inputs may request at once. The code holds all twelve together when all six pairs trigger at once.
// R4: Held samples convert two at a time through the input multiplexers.
// R5: Each slot yields two 10-bit results within one microsecond. The code takes 11 cycles (1.1 us) from core_start_ff to result_valid_ff.
// R6: In Sleep no sampling or conversion takes place.
// R7: Each pair's sample-and-hold triggers independently of the others.
// R8: Conversion runs only while the oscillator select field enables the PLL.
// R9: A per-pin select chooses analog input or digital input/output.
// R10: A trigger arriving while busy stays pending until its pair is served.
`ifndef PAS_DEFS_VH
`define PAS_DEFS_VH

`define PAS_NUM_PAIRS     6
`define PAS_NUM_INPUTS    12
`define PAS_MAX_SAMPLE    4
`define PAS_RES_W         10
`define PAS_TRIG_W        4
`define PAS_NUM_TRIG      16
`define PAS_OSC_PLL       2'h1
`define PAS_CLK_MHZ       10
`define PAS_SLOT_NS       1000
`define PAS_SLOT_CYC      ((`PAS_SLOT_NS * `PAS_CLK_MHZ) / 1000)
`define PAS_CNT_W         4

`endif

// ==== src/pas_sequencer.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pas_defs.vh"
module pas_sequencer
(
    input  wire                          mclk,
    input  wire                          rst_n,
    input  wire [`PAS_NUM_TRIG-1:0]      trig_src,
    input  wire [23:0]                   pair_trig_sel,
    input  wire [`PAS_NUM_INPUTS-1:0]    pin_analog_select,
    input  wire [1:0]                    oscillator_select_field,
    input  wire                          sleep_mode,
    input  wire                          conv_enable,
    input  wire [`PAS_RES_W-1:0]         core_result_a,
    input  wire [`PAS_RES_W-1:0]         core_result_b,
    output wire [`PAS_NUM_INPUTS-1:0]    pin_digital_en,
    output reg  [`PAS_NUM_INPUTS-1:0]    sample_hold_ff,
    output reg  [3:0]                    mux_sel_a_ff,
    output reg  [3:0]                    mux_sel_b_ff,
    output reg                           core_start_ff,
    output reg  [`PAS_NUM_PAIRS-1:0]     pending_ff,
    output reg  [`PAS_RES_W-1:0]         result_even_ff,
    output reg  [`PAS_RES_W-1:0]         result_odd_ff,
    output reg  [2:0]                    result_pair_ff,
    output reg                           result_valid_ff,
    output wire                          busy
);
    // ------------------------------------------------------------
    // States and slot timing.
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CONV = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;
    localparam integer          SLOT_LAST_N = `PAS_SLOT_CYC - 1;
    localparam [`PAS_CNT_W-1:0] SLOT_LAST   =
        SLOT_LAST_N[`PAS_CNT_W-1:0];

    reg  [1:0]                state_ff;
    reg  [1:0]                nxt_state;
    reg  [`PAS_CNT_W-1:0]     cnt_ff;
    reg  [2:0]                cur_pair_ff;
    reg  [`PAS_NUM_TRIG-1:0]  trig_prev_ff;
    wire [`PAS_NUM_TRIG-1:0]  trig_sync;
    wire [`PAS_NUM_TRIG-1:0]  trig_rise;
    reg  [`PAS_NUM_PAIRS-1:0] pair_hit;
    reg  [`PAS_NUM_PAIRS-1:0] nxt_pending;
    reg  [2:0]                first_pair;
    reg                       any_pending;
    wire                      run_ok;
    wire                      start_slot;
    wire                      slot_end;
    integer                   i;
    integer                   j;

    // ------------------------------------------------------------
    // Trigger synchronisers.
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PAS_NUM_TRIG; g = g + 1)
        begin : g_sync
            pas_sync2 u_sync
            (
                .mclk  (mclk),
                .rst_n (rst_n),
                .din   (trig_src[g]),
                .dout  (trig_sync[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Trigger edge detection.
    // ------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
            trig_prev_ff <= {`PAS_NUM_TRIG{1'b0}};
        else
            trig_prev_ff <= trig_sync;
    end

    assign trig_rise = trig_sync & ~trig_prev_ff;

    // ------------------------------------------------------------
    // Run gate and pin mode.
    // ------------------------------------------------------------
    // R9: pin mode select
    assign pin_digital_en = ~pin_analog_select;

    // R8: PLL gate
    // R6: sleep stall
    assign run_ok = conv_enable & ~sleep_mode &
                    (oscillator_select_field == `PAS_OSC_PLL);

    // ------------------------------------------------------------
    // Slot status.
    // ------------------------------------------------------------
    assign busy       = (state_ff != ST_IDLE);
    assign start_slot = (state_ff == ST_IDLE) & any_pending & run_ok;
    assign slot_end   = (cnt_ff == SLOT_LAST);

    // ------------------------------------------------------------
    // Pending requests and priority.
    // ------------------------------------------------------------
    always @*
    begin
        pair_hit    = {`PAS_NUM_PAIRS{1'b0}};
        first_pair  = 3'h0;
        any_pending = 1'b0;
        for (i = 0; i < `PAS_NUM_PAIRS; i = i + 1)
        begin
            // R2: per pair source
            // R7: independent triggers
            pair_hit[i] = trig_rise[pair_trig_sel[i*4 +: 4]] &
                          (pin_analog_select[2*i] |
                           pin_analog_select[2*i+1]);
        end
        // R1: lowest pair first
        for (i = `PAS_NUM_PAIRS - 1; i >= 0; i = i - 1)
        begin
            if (pending_ff[i])
            begin
                first_pair  = i[2:0];
                any_pending = 1'b1;
            end
        end
        // R10: hold while busy
        // R3: twelve outstanding inputs
        nxt_pending = pending_ff | (run_ok ? pair_hit :
                                    {`PAS_NUM_PAIRS{1'b0}});
        if (start_slot)
            nxt_pending[first_pair] = pair_hit[first_pair];
    end

    // ------------------------------------------------------------
    // Slot state machine.
    // ------------------------------------------------------------
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (any_pending && run_ok)
                    nxt_state = ST_CONV;
            ST_CONV:
                if (!run_ok)
                    nxt_state = ST_IDLE;
                else if (slot_end)
                    nxt_state = ST_DONE;
            ST_DONE:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Slot, hold and result registers.
    // ------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_ff        <= ST_IDLE;
            cnt_ff          <= {`PAS_CNT_W{1'b0}};
            cur_pair_ff     <= 3'h0;
            pending_ff      <= {`PAS_NUM_PAIRS{1'b0}};
            sample_hold_ff  <= {`PAS_NUM_INPUTS{1'b0}};
            mux_sel_a_ff    <= 4'h0;
            mux_sel_b_ff    <= 4'h0;
            core_start_ff   <= 1'b0;
            result_even_ff  <= {`PAS_RES_W{1'b0}};
            result_odd_ff   <= {`PAS_RES_W{1'b0}};
            result_pair_ff  <= 3'h0;
            result_valid_ff <= 1'b0;
        end
        else
        begin
            state_ff        <= nxt_state;
            pending_ff      <= nxt_pending;
            core_start_ff   <= 1'b0;
            result_valid_ff <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    cnt_ff <= {`PAS_CNT_W{1'b0}};
                    if (any_pending && run_ok)
                    begin
                        cur_pair_ff   <= first_pair;
                        // R4: two through muxes
                        mux_sel_a_ff  <= {first_pair, 1'b0};
                        mux_sel_b_ff  <= {first_pair, 1'b1};
                        core_start_ff <= 1'b1;
                    end
                end
                ST_CONV:
                    cnt_ff <= cnt_ff + 1'b1;
                ST_DONE:
                begin
                    // R5: two results per slot
                    result_even_ff  <= core_result_a;
                    result_odd_ff   <= core_result_b;
                    result_pair_ff  <= cur_pair_ff;
                    result_valid_ff <= 1'b1;
                    sample_hold_ff[{cur_pair_ff, 1'b0}] <= 1'b0;
                    sample_hold_ff[{cur_pair_ff, 1'b1}] <= 1'b0;
                end
                default:
                    cnt_ff <= {`PAS_CNT_W{1'b0}};
            endcase
            // A new trigger wins over the clear of the finished pair.
            // R3: hold per pair
            for (j = 0; j < `PAS_NUM_PAIRS; j = j + 1)
            begin
                if (run_ok && pair_hit[j])
                begin
                    sample_hold_ff[2*j]   <= 1'b1;
                    sample_hold_ff[2*j+1] <= 1'b1;
                end
            end
            if (!run_ok)
                sample_hold_ff <= {`PAS_NUM_INPUTS{1'b0}};
        end
    end
endmodule
`default_nettype wire

// ==== src/pas_sync2.v ====
`timescale 1ns/100ps
`default_nettype none
module pas_sync2
(
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        din,
    output wire        dout
);
    reg                meta_ff;
    reg                sync_ff;

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

// ==== test/pas_pwm_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Trigger sources, each stretched by one cycle.
// ----------------------------------------
module pas_pwm_model
(
    input  wire logic        mclk,
    input  wire logic [15:0] fire,
    output var  logic [15:0] trig_src
);
    logic [15:0] dly_ff;
    initial trig_src = 16'h0000;
    initial dly_ff = 16'h0000;
    always @(negedge mclk)
    begin
        dly_ff   <= fire;
        trig_src <= fire | dly_ff;
    end
endmodule
`default_nettype wire

// ==== test/pas_seq_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checks of the sequencer.
// ----------------------------------------
module pas_seq_props
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [11:0] pin_analog_select,
    input wire logic [1:0]  oscillator_select_field,
    input wire logic        sleep_mode,
    input wire logic [11:0] pin_digital_en,
    input wire logic [3:0]  mux_sel_a_ff,
    input wire logic [3:0]  mux_sel_b_ff,
    input wire logic        core_start_ff,
    input wire logic [5:0]  pending_ff,
    input wire logic        result_valid_ff,
    input wire logic        busy
);
    logic [5:0] pend_q;
    always @(posedge mclk)
        pend_q <= pending_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_dig; pin_digital_en == ~pin_analog_select; endproperty
    a_dig: assert property (p_dig) else $error("digital enable wrong");
    property p_mux; core_start_ff |-> !mux_sel_a_ff[0]
        && mux_sel_b_ff == mux_sel_a_ff + 4'h1; endproperty
    a_mux: assert property (p_mux) else $error("input pair wrong");
    property p_lat; core_start_ff |-> ##11 result_valid_ff; endproperty
    a_lat: assert property (p_lat) else $error("slot too slow");
    property p_slp; sleep_mode |=> !core_start_ff; endproperty
    a_slp: assert property (p_slp) else $error("start in sleep");
    property p_osc; oscillator_select_field != 2'h1 |=> !core_start_ff;
    endproperty
    a_osc: assert property (p_osc) else $error("start without pll");
    property p_low; core_start_ff |-> pend_q[mux_sel_a_ff[3:1]] && (pend_q
        & ((6'h01 << mux_sel_a_ff[3:1]) - 6'h01)) == 6'h00; endproperty
    a_low: assert property (p_low) else $error("not lowest pair");
    property p_hold; busy && !core_start_ff && !sleep_mode
        |-> (pending_ff & pend_q) == pend_q; endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_end; result_valid_ff |-> !busy && $past(busy); endproperty
    a_end: assert property (p_end) else $error("busy wrong at end");
endmodule
bind pas_sequencer pas_seq_props pas_seq_props_inst (.mclk, .rst_n,
    .pin_analog_select, .oscillator_select_field, .sleep_mode,
    .pin_digital_en, .mux_sel_a_ff, .mux_sel_b_ff, .core_start_ff,
    .pending_ff, .result_valid_ff, .busy);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
// ----------------------------------------
// Sequencer bench.
// ----------------------------------------
module tb_top;
    logic        mclk, rst_n, sleep_mode, conv_enable, core_start_ff;
    logic        result_valid_ff, busy;
    logic [15:0] fire, trig_src, m;
    logic [23:0] pair_trig_sel;
    logic [11:0] pin_analog_select, pin_digital_en, sample_hold_ff;
    logic [1:0]  oscillator_select_field;
    logic [9:0]  core_result_a, core_result_b, result_even_ff, result_odd_ff;
    logic [3:0]  mux_sel_a_ff, mux_sel_b_ff;
    logic [5:0]  pending_ff, served;
    logic [2:0]  result_pair_ff;
    int          error_cnt, checked, k;
    pas_sequencer pas_sequencer_inst (.mclk, .rst_n, .trig_src,
        .pair_trig_sel, .pin_analog_select, .oscillator_select_field,
        .sleep_mode, .conv_enable, .core_result_a, .core_result_b,
        .pin_digital_en, .sample_hold_ff, .mux_sel_a_ff, .mux_sel_b_ff,
        .core_start_ff, .pending_ff, .result_even_ff, .result_odd_ff,
        .result_pair_ff, .result_valid_ff, .busy);
    pas_pwm_model pas_pwm_model_inst (.mclk, .fire, .trig_src);
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    function automatic logic [5:0] exp_pend(input logic [15:0] t);
        exp_pend = 6'h00;
        for (int i = 0; i < 6; i++)
            exp_pend[i] = t[pair_trig_sel[4*i+:4]] & |pin_analog_select[2*i+:2];
    endfunction
    always @(posedge mclk)
    begin
        if (rst_n && core_start_ff === 1'b1)
            `CHK("held", 2'b11, sample_hold_ff[mux_sel_a_ff+:2])
        if (rst_n && result_valid_ff === 1'b1)
        begin
            served[result_pair_ff] <= 1'b1;
            `CHK("even", core_result_a, result_even_ff)
            `CHK("odd", core_result_b, result_odd_ff)
            `CHK("freed", 2'b00, sample_hold_ff[2*result_pair_ff+:2])
        end
    end
    task run(input logic [15:0] t, input logic [5:0] e, input string nm);
        served = 6'h00;
        fire <= t;
        @(negedge mclk);
        fire <= 16'h0000;
        repeat (6) @(negedge mclk);
        for (k = 0; k < 200 && (busy !== 1'b0 || pending_ff !== 6'h00); k++)
            @(negedge mclk);
        repeat (2) @(negedge mclk);
        `CHK(nm, e, served)
        `CHK("hold", 12'h000, sample_hold_ff)
        $display("Test %s done", nm);
    endtask
    task stop_test;
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #1000000;
        error_cnt++;
        stop_test;
    end
    initial
    begin
        {rst_n, sleep_mode, fire, served, error_cnt, checked} = 0;
        {core_result_a, core_result_b} = 20'h00000;
        conv_enable = 1'b1;
        oscillator_select_field = 2'h1;
        pair_trig_sel = 24'h543210;
        pin_analog_select = 12'hFFF;
        k = $urandom(95278);
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        run(16'hFFFF, 6'h3F, "all");
        fire <= 16'h0020;
        repeat (8) @(negedge mclk);
        run(16'h0001, 6'h21, "busy");
        for (int s = 0; s < 16; s++)
        begin
            pair_trig_sel = {6{s[3:0]}};
            run(16'h0001 << s, 6'h3F, "code");
        end
        repeat (20)
        begin
            pair_trig_sel = 24'($urandom);
            pin_analog_select = k[0] ? 12'hFFF : 12'($urandom);
            k = $urandom;
            {core_result_a, core_result_b} = 20'($urandom);
            m = 16'($urandom);
            run(m, exp_pend(m), "rand");
        end
        pair_trig_sel = 24'h543210;
        pin_analog_select = 12'hFFF;
        for (int c = 0; c < 3; c++)
        begin
            sleep_mode = (c == 0);
            oscillator_select_field = (c == 1) ? 2'h2 : 2'h1;
            conv_enable = (c != 2);
            run(16'hFFFF, 6'h00, "off");
        end
        {sleep_mode, conv_enable} = 2'h1;
        oscillator_select_field = 2'h1;
        run(16'h0008, 6'h08, "wake");
        stop_test;
    end
endmodule
`default_nettype wire
